//--- hw/dedicated_ref_clock_in_ctrl.sv
// Reference clock selection, reset qualification and receive word clock derivation.
// Assumes clocks from pins arrive as enable-style levels sampled on MCLK_I.
// Summary of operation
// - Rate high expects reference at line/16.
// - Rate low expects reference at line/32.
// - Rate select ignored when source select low.
// - Source low selects transmit word clock.
// - Source high selects dedicated reference input.
// - Selected reference drives SEL_REF_CLK_O; transmit serial clock is line/2 from line ticks.
// - Recovery loop centres and checks lock on reference.
// - Reset low for 1 us resets device.
// - Primary receive clock is recovered clock divided.
// - Lock-to-reference keeps receive clock stable without data.
// - Control low locks loop to reference, high data.
// - Word is 4 bits; clock is line/4.
`timescale 1ns/1ps
module dedicated_ref_clock_in_ctrl
  import dedicated_ref_clock_in_ctrl_pkg::*;
(
  // System.
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // Pins.
  input wire logic RESET_N_I,
  input wire logic DEDICATED_REF_CLOCK_IN_I,
  input wire logic TX_WORD_CLOCK_IN_I,
  input wire logic LINE_TICK_I,
  input wire logic RECOV_TICK_I,
  // Clock outputs.
  output logic SEL_REF_CLK_O,
  output logic TX_SERIAL_CLOCK_OUT_O,
  output logic RX_PRIMARY_WORD_CLOCK_O,
  output logic LOCK_TO_REF_O,
  output logic DEV_RST_O,
  // AXI4-Lite.
  input wire logic [3:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [3:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);
  typedef struct packed {
    logic [2:0] rst_s;
    logic [2:0] ref_s;
    logic [2:0] tx_s;
    logic rst_n_q;
    logic ref_q;
    logic tx_q;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic dev_rst;
    logic [2:0] ctrl;
    logic sel_cur;
    logic sel_clk;
    sw_state_t sw;
    logic awok;
    logic wok;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic lockref;
    logic tx_out;
    logic rx_out;
  } st_t;
  st_t s_r;
  st_t s_nxt;
  logic sel_want;
  logic [5:0] ref_ratio;
  logic [5:0] tx_ratio;
  logic [5:0] rx_ratio;
  logic tx_clk;
  logic rx_clk;
  logic rx_tick;
  logic tx_pulse;
  logic rx_pulse;
  // Source low uses word clock, so rate only counts when source high.
  assign sel_want = s_r.ctrl[CTRL_SRC_BIT];
  assign ref_ratio = (s_r.ctrl[CTRL_SRC_BIT] && s_r.ctrl[CTRL_RATE_BIT]) ? REF_DIV_HIGH : REF_DIV_LOW;
  assign tx_ratio = DIV_HALF_WORD;
  // Transmit serial clock runs at half the line tick rate whatever the reference does; modelled by line ticks.
  assign rx_tick = s_r.ctrl[CTRL_LTR_BIT] ? RECOV_TICK_I : LINE_TICK_I;
  assign rx_ratio = WORD_DIV;
  word_clk_div tx_div_u (
    .clk_i(MCLK_I),
    .rst_i(s_r.dev_rst),
    .tick_i(LINE_TICK_I),
    .ratio_i(tx_ratio),
    .clk_o(tx_clk),
    .pulse_o(tx_pulse)
  );
  word_clk_div rx_div_u (
    .clk_i(MCLK_I),
    .rst_i(s_r.dev_rst),
    .tick_i(rx_tick),
    .ratio_i(rx_ratio),
    .clk_o(rx_clk),
    .pulse_o(rx_pulse)
  );
  logic aw_go;
  logic w_go;
  always_comb
  begin
    s_nxt = s_r;
    aw_go = AWVALID_I && !s_r.awok && !s_r.bvalid;
    w_go = WVALID_I && !s_r.wok && !s_r.bvalid;
    // Three-stage pin synchronisers; change counts when stages two and three agree.
    s_nxt.rst_s = {s_r.rst_s[1:0], RESET_N_I};
    s_nxt.ref_s = {s_r.ref_s[1:0], DEDICATED_REF_CLOCK_IN_I};
    s_nxt.tx_s = {s_r.tx_s[1:0], TX_WORD_CLOCK_IN_I};
    if (s_r.rst_s[1] == s_r.rst_s[2])
      s_nxt.rst_n_q = s_r.rst_s[2];
    if (s_r.ref_s[1] == s_r.ref_s[2])
      s_nxt.ref_q = s_r.ref_s[2];
    if (s_r.tx_s[1] == s_r.tx_s[2])
      s_nxt.tx_q = s_r.tx_s[2];
    // Short glitches on the reset pin are ignored until the low time is met.
    if (s_r.rst_n_q)
    begin
      s_nxt.rst_cnt = '0;
      s_nxt.dev_rst = 1'b0;
    end
    else if (s_r.rst_cnt >= RST_CNT_W'(RST_MIN_LOW_CYC - 1))
      s_nxt.dev_rst = 1'b1;
    else
      s_nxt.rst_cnt = s_r.rst_cnt + 1'b1;
    // Switch only while the output is low, so no high phase is cut short.
    case (s_r.sw)
      SW_RUN:
      begin
        s_nxt.sel_clk = s_r.sel_cur ? s_r.ref_q : s_r.tx_q;
        if (sel_want != s_r.sel_cur)
          s_nxt.sw = SW_DROP;
      end
      SW_DROP:
      begin
        s_nxt.sel_clk = s_r.sel_cur ? s_r.ref_q : s_r.tx_q;
        if (!(s_r.sel_cur ? s_r.ref_q : s_r.tx_q))
        begin
          s_nxt.sel_clk = 1'b0;
          s_nxt.sw = SW_WAIT;
        end
      end
      SW_WAIT:
      begin
        s_nxt.sel_clk = 1'b0;
        s_nxt.sel_cur = sel_want;
        s_nxt.sw = SW_PICK;
      end
      SW_PICK:
      begin
        s_nxt.sel_clk = 1'b0;
        if (!(s_r.sel_cur ? s_r.ref_q : s_r.tx_q))
          s_nxt.sw = SW_RUN;
      end
      default:
        s_nxt.sw = SW_RUN;
    endcase
    // AXI4-Lite write path.
    if (aw_go)
    begin
      s_nxt.awok = 1'b1;
      s_nxt.awaddr = AWADDR_I;
    end
    if (w_go)
    begin
      s_nxt.wok = 1'b1;
      s_nxt.wdata = WDATA_I;
      s_nxt.wstrb = WSTRB_I;
    end
    if (s_r.awok && s_r.wok && !s_r.bvalid)
    begin
      s_nxt.awok = 1'b0;
      s_nxt.wok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      if (s_r.awaddr[3:2] == ADDR_CTRL[3:2])
      begin
        if (s_r.wstrb[0])
          s_nxt.ctrl = s_r.wdata[2:0];
      end
      else if (s_r.awaddr[3:2] != ADDR_STAT[3:2] && s_r.awaddr[3:2] != ADDR_RATIO[3:2])
        s_nxt.bresp = RESP_SLVERR;
    end
    if (s_r.bvalid && BREADY_I)
      s_nxt.bvalid = 1'b0;
    // AXI4-Lite read path.
    if (ARVALID_I && !s_r.rvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h00000000;
      case (ARADDR_I[3:2])
        ADDR_CTRL[3:2]: s_nxt.rdata[2:0] = s_r.ctrl;
        ADDR_STAT[3:2]:
        begin
          s_nxt.rdata[STAT_SEL_BIT] = s_r.sel_cur;
          s_nxt.rdata[STAT_LOCKREF_BIT] = !s_r.ctrl[CTRL_LTR_BIT];
          s_nxt.rdata[STAT_RST_BIT] = s_r.dev_rst;
          s_nxt.rdata[STAT_BUSY_BIT] = (s_r.sw != SW_RUN);
        end
        ADDR_RATIO[3:2]: s_nxt.rdata[5:0] = ref_ratio;
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    if (s_r.rvalid && RREADY_I)
      s_nxt.rvalid = 1'b0;
    // Readies and lock output are flops too, so each is worked out from the next state; clock outputs copy the divider outputs.
    s_nxt.awrdy = !s_nxt.awok && !s_nxt.bvalid;
    s_nxt.wrdy = !s_nxt.wok && !s_nxt.bvalid;
    s_nxt.arrdy = !s_nxt.rvalid;
    s_nxt.lockref = !s_nxt.ctrl[CTRL_LTR_BIT];
    s_nxt.tx_out = tx_clk;
    s_nxt.rx_out = rx_clk;
  end
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      s_r <= '0;
      s_r.rst_s <= 3'h7;
      s_r.rst_n_q <= 1'b1;
      s_r.ctrl <= CTRL_RESET;
      s_r.sel_cur <= 1'b1;
      s_r.sw <= SW_RUN;
      s_r.awrdy <= 1'b1;
      s_r.wrdy <= 1'b1;
      s_r.arrdy <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign SEL_REF_CLK_O = s_r.sel_clk;
  assign TX_SERIAL_CLOCK_OUT_O = s_r.tx_out;
  assign RX_PRIMARY_WORD_CLOCK_O = s_r.rx_out;
  assign LOCK_TO_REF_O = s_r.lockref;
  assign DEV_RST_O = s_r.dev_rst;
  assign AWREADY_O = s_r.awrdy;
  assign WREADY_O = s_r.wrdy;
  assign BVALID_O = s_r.bvalid;
  assign BRESP_O = s_r.bresp;
  assign ARREADY_O = s_r.arrdy;
  assign RVALID_O = s_r.rvalid;
  assign RDATA_O = s_r.rdata;
  assign RRESP_O = s_r.rresp;
  // Checker-only count of qualified low cycles, kept apart so the reset check does not trust the design counter.
  logic [RST_CNT_W-1:0] low_run_r;
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I || s_r.rst_n_q)
      low_run_r <= '0;
    else if (low_run_r != '1)
      low_run_r <= low_run_r + 1'b1;
  end
  rst_wait_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    $rose(s_r.dev_rst) |-> s_r.rst_cnt >= RST_CNT_W'(RST_MIN_LOW_CYC - 1))
    else $error("Internal reset raised before the low time.");
  rst_rel_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_r.rst_n_q |=> !s_r.dev_rst)
    else $error("Internal reset held after pin released.");
  rate_ign_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    !s_r.ctrl[CTRL_SRC_BIT] |-> ref_ratio == REF_DIV_LOW)
    else $error("Rate select acted with word clock source.");
  rate_hi_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (s_r.ctrl[CTRL_SRC_BIT] && s_r.ctrl[CTRL_RATE_BIT]) |-> ref_ratio == REF_DIV_HIGH)
    else $error("Wrong ratio for high rate.");
  rate_lo_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (s_r.ctrl[CTRL_SRC_BIT] && !s_r.ctrl[CTRL_RATE_BIT]) |-> ref_ratio == REF_DIV_LOW)
    else $error("Wrong ratio for low rate.");
  sel_run_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (s_r.sw == SW_RUN && $past(s_r.sw) == SW_RUN && sel_want == s_r.sel_cur && $past(sel_want) == s_r.sel_cur)
    |-> s_r.sel_clk == $past(s_r.sel_cur ? s_r.ref_q : s_r.tx_q))
    else $error("Selected clock does not follow chosen source.");
  no_runt_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (s_r.sw == SW_WAIT || s_r.sw == SW_PICK) |-> !s_r.sel_clk)
    else $error("Clock high during source change.");
  ltr_src_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    !s_r.ctrl[CTRL_LTR_BIT] |-> rx_tick == LINE_TICK_I)
    else $error("Loop not on reference while forced.");
  word_div_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I || s_r.dev_rst)
    rx_pulse |=> !rx_pulse [*3])
    else $error("Word clock faster than one per four bits.");
  rst_len_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    $rose(s_r.dev_rst) |-> low_run_r >= RST_CNT_W'(RST_MIN_LOW_CYC))
    else $error("Internal reset raised before the pin was low long enough.");
  rst_div_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_r.dev_rst |=> !tx_pulse && !rx_pulse)
    else $error("Dividers kept running in device reset.");
  tx_div_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I || s_r.dev_rst)
    tx_pulse |=> !tx_pulse)
    else $error("Transmit clock faster than half the tick rate.");
  ltr_tick_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_r.ctrl[CTRL_LTR_BIT] |-> rx_tick == RECOV_TICK_I)
    else $error("Loop not on data while unforced.");
  drop_low_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (s_r.sw == SW_DROP && !(s_r.sel_cur ? s_r.ref_q : s_r.tx_q)) |=> (!s_r.sel_clk && s_r.sw == SW_WAIT))
    else $error("Old clock not parked low before the change.");
  wait_sel_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    s_r.sw == SW_WAIT |=> s_r.sel_cur == $past(sel_want))
    else $error("Wrong source taken during the change.");
  pick_run_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (s_r.sw == SW_PICK && !(s_r.sel_cur ? s_r.ref_q : s_r.tx_q)) |=> s_r.sw == SW_RUN)
    else $error("Switch did not resume on a low new clock.");
  // The bus answer must stand until the master takes it.
  resp_hold_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (BVALID_O && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O)))
    else $error("Write response dropped before it was taken.");
  read_hold_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    (RVALID_O && !RREADY_I) |=> (RVALID_O && $stable(RDATA_O) && $stable(RRESP_O)))
    else $error("Read data dropped before it was taken.");
  write_busy_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    BVALID_O |-> (!AWREADY_O && !WREADY_O))
    else $error("Write accepted while a response is pending.");
  ar_busy_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    RVALID_O |-> !ARREADY_O)
    else $error("Read accepted while data is pending.");
  sw_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) s_r.sw == SW_PICK ##1 s_r.sw == SW_RUN);
  rst_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) $rose(s_r.dev_rst));
  wr_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) s_r.bvalid && BREADY_I);
  tx_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) tx_pulse);
  ltr_c: cover property (@(posedge MCLK_I) disable iff (SYS_RST_I) $fell(s_r.ctrl[CTRL_LTR_BIT]));
endmodule : dedicated_ref_clock_in_ctrl

//--- hw/dedicated_ref_clock_in_ctrl_pkg.sv
// Constants shared by the reference clock control block and its divider.
// Assumes a 100 MHz system clock and an AXI4-Lite register master.
package dedicated_ref_clock_in_ctrl_pkg;
  // Clock period and reset qualification time.
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_MIN_LOW_NS = 1000;
  localparam int RST_MIN_LOW_CYC = (RST_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;
  // Reference, word clock and transmit divide ratios against the serial line rate.
  localparam logic [5:0] REF_DIV_HIGH = 6'h10;
  localparam logic [5:0] REF_DIV_LOW = 6'h20;
  localparam logic [5:0] WORD_DIV = 6'h04;
  localparam logic [5:0] DIV_HALF_WORD = 6'h02;
  // Register byte addresses.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_RATIO = 4'h8;
  // Control field positions and reset value.
  localparam int CTRL_RATE_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_LTR_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h7;
  // Status field positions and bus response codes.
  localparam int STAT_SEL_BIT = 0;
  localparam int STAT_LOCKREF_BIT = 1;
  localparam int STAT_RST_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Glitch-free switch states.
  typedef enum logic [3:0] {
    SW_RUN = 4'h1,
    SW_DROP = 4'h2,
    SW_WAIT = 4'h4,
    SW_PICK = 4'h8
  } sw_state_t;
endpackage : dedicated_ref_clock_in_ctrl_pkg

//--- hw/word_clk_div.sv
// Divides an enable-pulse clock stream by a given even ratio.
// Assumes tick_i pulses once per fast clock edge and ratio is even and nonzero.
`timescale 1ns/1ps
module word_clk_div
  import dedicated_ref_clock_in_ctrl_pkg::*;
(
  // System.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic tick_i,
  input wire logic [5:0] ratio_i,
  // Output.
  output logic clk_o,
  output logic pulse_o
);
  typedef struct packed {
    logic [5:0] cnt;
    logic clk;
    logic pulse;
  } div_t;
  div_t s_r;
  div_t s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    if (tick_i)
    begin
      if (s_r.cnt >= (ratio_i >> 1) - 6'h01)
      begin
        s_nxt.cnt = 6'h00;
        s_nxt.clk = ~s_r.clk;
        s_nxt.pulse = ~s_r.clk;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 6'h01;
      end
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign clk_o = s_r.clk;
  assign pulse_o = s_r.pulse;
endmodule : word_clk_div

//--- tb/dedicated_ref_clock_in_far_model.sv
// Far-side model: board reference, transmit word clock and recovered ticks.
// Assumes one free-running system clock; all rates are derived from it.
`timescale 1ns/1ps
module dedicated_ref_clock_in_far_model
(
  input wire logic clk_i,
  input wire logic rate_high_i,
  input wire logic ref_en_i,
  input wire logic txw_en_i,
  input wire logic data_en_i,
  output logic ref_clk_o,
  output logic txw_clk_o,
  output logic recov_tick_o
);
  logic [4:0] cnt_r = 5'h00;
  always @(posedge clk_i)
  begin
    cnt_r <= cnt_r + 5'h01;
  end
  // One line tick per cycle, so the board supplies line/16 or line/32.
  assign ref_clk_o = ref_en_i & (rate_high_i ? cnt_r[3] : cnt_r[4]);
  // A stopped clock stands low rather than holding a stale level.
  assign txw_clk_o = txw_en_i & cnt_r[2];
  assign recov_tick_o = data_en_i;
endmodule : dedicated_ref_clock_in_far_model

//--- tb/tb.sv
// Self-checking bench for the reference clock control block.
// Assumes the far-side model supplies clocks and this bench masters the register bus.
`timescale 1ns/1ps
module tb;
  import dedicated_ref_clock_in_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_n = 1'b1;
  logic rate_hi = 1'b1;
  logic ref_en = 1'b1;
  logic data_en = 1'b1;
  logic refc, txwc, rtick, sel, txs, wc, lock_to_reference_ctrl, dev_rst, seen;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] mon, mon_q = 3'h0;
  int tg[3];
  int run = 0;
  int minrun = 999;
  int checks = 0;
  int miscompares = 0;
  always #5 clk = ~clk;
  dedicated_ref_clock_in_far_model i_dedicated_ref_clock_in_far_model (.clk_i(clk), .rate_high_i(rate_hi), .ref_en_i(ref_en), .txw_en_i(1'b1),
    .data_en_i(data_en), .ref_clk_o(refc), .txw_clk_o(txwc), .recov_tick_o(rtick));
  dedicated_ref_clock_in_ctrl i_dedicated_ref_clock_in_ctrl (.MCLK_I(clk), .SYS_RST_I(rst), .RESET_N_I(rst_n), .DEDICATED_REF_CLOCK_IN_I(refc),
    .TX_WORD_CLOCK_IN_I(txwc), .LINE_TICK_I(1'b1), .RECOV_TICK_I(rtick), .SEL_REF_CLK_O(sel),
    .TX_SERIAL_CLOCK_OUT_O(txs), .RX_PRIMARY_WORD_CLOCK_O(wc), .LOCK_TO_REF_O(lock_to_reference_ctrl), .DEV_RST_O(dev_rst),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready));
  assign mon = {txs, wc, sel};
  // The run length survives window starts, so the first edge in a window is never a false runt.
  always @(posedge clk)
  begin
    mon_q <= mon;
    run <= (mon[0] !== mon_q[0]) ? 1 : run + 1;
    if (mon[0] !== mon_q[0] && run < minrun)
      minrun <= run;
    for (int k = 0; k < 3; k++)
      if (mon[k] !== mon_q[k])
        tg[k] <= tg[k] + 1;
    if (dev_rst === 1'b1)
      seen <= 1'b1;
  end
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n >= 50)
    begin
      miscompares++;
      summarize();
    end
  endtask : tmo
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    tmo(n);
    // One idle edge keeps the next call from raising a strobe in the step that lowered it.
    @(posedge clk);
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    tmo(n);
    @(posedge clk);
    chk(rdata & msk, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd_chk
  task automatic win;
    @(negedge clk);
    tg = '{0, 0, 0};
    minrun = 999;
    repeat (320) @(posedge clk);
    @(negedge clk);
  endtask : win
  task automatic rng(input int k, input int lo, input int hi);
    checks++;
    if (tg[k] < lo || tg[k] > hi)
    begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, tg[k], lo, hi);
    end
  endtask : rng
  initial
  begin
    seen = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(ADDR_CTRL, 32'h7, 32'hFFFFFFFF, RESP_OKAY);
    rd_chk(ADDR_RATIO, 32'h10, 32'h3F, RESP_OKAY);
    rd_chk(ADDR_STAT, 32'h1, 32'h1, RESP_OKAY);
    rd_chk(4'hC, 32'h0, 32'h0, RESP_SLVERR);
    wr(4'hC, 32'h0, RESP_SLVERR);
    win();
    rng(0, 38, 42);
    rng(2, 316, 320);
    rng(1, 156, 160);
    rate_hi <= 1'b0;
    wr(ADDR_CTRL, 32'h6, RESP_OKAY);
    rd_chk(ADDR_RATIO, 32'h20, 32'h3F, RESP_OKAY);
    win();
    rng(0, 18, 22);
    // The reference stops only after the switch, so a cut board clock is never blamed on the mux.
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    repeat (40) @(posedge clk);
    rd_chk(ADDR_STAT, 32'h0, 32'h9, RESP_OKAY);
    ref_en <= 1'b0;
    win();
    rng(0, 70, 82);
    chk(minrun >= 4, 32'h1);
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    rd_chk(ADDR_RATIO, 32'h20, 32'h3F, RESP_OKAY);
    win();
    rng(0, 78, 82);
    ref_en <= 1'b1;
    rate_hi <= 1'b1;
    data_en <= 1'b0;
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    win();
    chk({31'h0, lock_to_reference_ctrl}, 32'h1);
    rng(1, 156, 160);
    chk(minrun >= 4, 32'h1);
    rd_chk(ADDR_STAT, 32'h3, 32'h3, RESP_OKAY);
    wr(ADDR_CTRL, 32'h7, RESP_OKAY);
    win();
    chk({31'h0, lock_to_reference_ctrl}, 32'h0);
    rng(1, 0, 1);
    rst_n <= 1'b0;
    repeat (120) @(posedge clk);
    chk({31'h0, dev_rst}, 32'h1);
    rd_chk(ADDR_STAT, 32'h4, 32'h4, RESP_OKAY);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({31'h0, dev_rst}, 32'h0);
    seen = 1'b0;
    rst_n <= 1'b0;
    repeat (50) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({31'h0, seen}, 32'h0);
    summarize();
  end
endmodule : tb
